/* File: ddc_pkg.sv */
// package for the display drive control register block
// assumes a 32-bit axi4-lite slave port and one 250 MHz clock
//
// Functional notes
// - sleep bit set stops driving during sleep
// - failed pattern write sets flag bit five
// - flag hardware set, software clears by zero
// - common count writes ignored while enabled
// - common field decodes commons and bias
// - register resets zero, bit5 hardware set
`default_nettype none
package ddc_pkg;
   // register byte addresses
   localparam logic [11:0] DDC_CTRL_OFS   = 12'h000;
   localparam logic [11:0] DDC_STAT_OFS   = 12'h004;
   localparam logic [11:0] DDC_IRQST_OFS  = 12'h008;
   localparam logic [11:0] DDC_IRQMSK_OFS = 12'h00c;
   // control field positions
   localparam int DDC_EN_BIT    = 7;
   localparam int DDC_SLP_BIT   = 6;
   localparam int DDC_PATTERN_WRITE_FAIL_FLAG_BIT  = 5;
   localparam int DDC_CS_BIT    = 4;
   localparam int DDC_MUX_LSB   = 0;
   localparam logic [7:0] DDC_CTRL_RST = 8'h00;
   localparam logic [3:0] DDC_MUX_MAX  = 4'h8;
   // interrupt status bit positions
   localparam int DDC_IRQ_PATTERN_WRITE_FAIL_FLAG  = 0;
   localparam int DDC_IRQ_WIDTH = 1;
   localparam logic [1:0] DDC_RESP_OKAY   = 2'b00;
   localparam logic [1:0] DDC_RESP_SLVERR = 2'b10;
   // bias codes reported on the status register
   typedef enum logic [1:0] {DDC_BIAS_OFF, DDC_BIAS_STATIC, DDC_BIAS_HALF, DDC_BIAS_THIRD}
      ddc_bias_t;
   // commons count 0..8 and bias from the select field
   function automatic logic [3:0] ddc_commons(input logic [3:0] sel);
      ddc_commons = (sel > DDC_MUX_MAX) ? 4'h0 : sel;
   endfunction : ddc_commons
   function automatic ddc_bias_t ddc_bias(input logic [3:0] sel);
      if (sel == 4'h0 || sel > DDC_MUX_MAX)
         ddc_bias = DDC_BIAS_OFF;
      else if (sel == 4'h1)
         ddc_bias = DDC_BIAS_STATIC;
      else if (sel == 4'h2)
         ddc_bias = DDC_BIAS_HALF;
      else
         ddc_bias = DDC_BIAS_THIRD;
   endfunction : ddc_bias
endpackage : ddc_pkg
`default_nettype wire

/* File: ddc_outreg.sv */
// output register stage for decoded drive controls
// assumes the same clock and asynchronous reset as the register block
`default_nettype none
module ddc_outreg
   import ddc_pkg::*;
#(
   parameter int W = 8
)(
   input  wire logic         ref_clk,
   input  wire logic         arst_n,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);
   // plain flop so every drive control leaves from a register
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         q <= '0;
      else
         q <= d;
   end
endmodule : ddc_outreg
`default_nettype wire

/* File: ddc_ctrl.sv */
// display drive control register with axi4-lite slave and interrupt
// assumes ref_clk at 250 MHz, pattern write failures arrive as pulses
`default_nettype none
module ddc_ctrl
   import ddc_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        arst_n,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output var  logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output var  logic        s_axi_wready,
   output var  logic [1:0]  s_axi_bresp,
   output var  logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output var  logic        s_axi_arready,
   output var  logic [31:0] s_axi_rdata,
   output var  logic [1:0]  s_axi_rresp,
   output var  logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        patternWriteFail,
   input  wire logic        sleepMode,
   output var  logic        driveActive,
   output var  logic        clockSelSecondary,
   output var  logic [3:0]  commonCount,
   output var  logic [1:0]  biasSel,
   output var  logic        irq
);
   logic [7:0]  ctrl_r;
   logic [7:0]  ctrl_nxt;
   logic [DDC_IRQ_WIDTH-1:0] irqSt_r;
   logic [DDC_IRQ_WIDTH-1:0] irqMsk_r;
   logic        awHeld_r;
   logic        wHeld_r;
   logic [11:0] awAddr_r;
   logic [7:0]  wData_r;
   logic        wLane0_r;
   logic        irq_r;

   // write channels are captured independently, in either order
   wire         awTake   = s_axi_awvalid && !awHeld_r && !s_axi_bvalid;
   wire         wTake    = s_axi_wvalid && !wHeld_r && !s_axi_bvalid;
   wire         doWrite  = awHeld_r && wHeld_r && !s_axi_bvalid;
   wire         lane0    = wLane0_r;
   wire         wrCtrl   = doWrite && lane0 && (awAddr_r == DDC_CTRL_OFS);
   wire         wrIrqSt  = doWrite && lane0 && (awAddr_r == DDC_IRQST_OFS);
   wire         wrIrqMsk = doWrite && lane0 && (awAddr_r == DDC_IRQMSK_OFS);
   wire         wrMapped = (awAddr_r == DDC_CTRL_OFS) || (awAddr_r == DDC_STAT_OFS)
                           || (awAddr_r == DDC_IRQST_OFS) || (awAddr_r == DDC_IRQMSK_OFS);
   wire         enNow    = ctrl_r[DDC_EN_BIT];
   wire         sleepNow = ctrl_r[DDC_SLP_BIT];

   // field update: pattern_write_fail_flag keeps zero-clear only, mux locked while enabled
   wire         werrNxt  = patternWriteFail ? 1'b1
                         : (wrCtrl && !wData_r[DDC_PATTERN_WRITE_FAIL_FLAG_BIT]) ? 1'b0
                         : ctrl_r[DDC_PATTERN_WRITE_FAIL_FLAG_BIT];
   wire [3:0]   muxNxt   = (wrCtrl && !enNow) ? wData_r[3:0] : ctrl_r[3:0];
   wire [2:0]   hiNxt    = wrCtrl ? {wData_r[7], wData_r[6], wData_r[4]}
                         : {ctrl_r[7], ctrl_r[6], ctrl_r[4]};
   assign ctrl_nxt = {hiNxt[2], hiNxt[1], werrNxt, hiNxt[0], muxNxt};

   // driver runs when enabled, unless sleep stops it
   wire         driveNxt = enNow && !(sleepMode && sleepNow);
   wire [3:0]   comNxt   = driveNxt ? ddc_commons(ctrl_r[3:0]) : 4'h0;
   wire [1:0]   biasNxt  = driveNxt ? 2'(ddc_bias(ctrl_r[3:0])) : 2'(DDC_BIAS_OFF);
   wire [7:0]   outQ;

   // status sticky set beats a same-cycle write-one clear
   wire [DDC_IRQ_WIDTH-1:0] irqSet = patternWriteFail;
   wire [DDC_IRQ_WIDTH-1:0] irqClr = wrIrqSt ? wData_r[DDC_IRQ_WIDTH-1:0] : '0;

   // read decode
   wire [31:0]  rdMux    = (s_axi_araddr == DDC_CTRL_OFS)   ? {24'h0, ctrl_r}
                         : (s_axi_araddr == DDC_STAT_OFS)   ? {24'h0, biasSel, commonCount,
                                                               clockSelSecondary, driveActive}
                         : (s_axi_araddr == DDC_IRQST_OFS)  ? {31'h0, irqSt_r}
                         : (s_axi_araddr == DDC_IRQMSK_OFS) ? {31'h0, irqMsk_r}
                         : 32'h0;
   wire         rdMapped = (s_axi_araddr == DDC_CTRL_OFS) || (s_axi_araddr == DDC_STAT_OFS)
                           || (s_axi_araddr == DDC_IRQST_OFS)
                           || (s_axi_araddr == DDC_IRQMSK_OFS);
   wire         arTake   = s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;

   // control register, reset to zero
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         ctrl_r <= DDC_CTRL_RST;
      else
         ctrl_r <= ctrl_nxt;
   end

   // interrupt status and mask
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         irqSt_r  <= '0;
         irqMsk_r <= '0;
         irq_r    <= 1'b0;
      end
      else
      begin
         irqSt_r  <= (irqSt_r & ~irqClr) | irqSet;
         if (wrIrqMsk)
            irqMsk_r <= wData_r[DDC_IRQ_WIDTH-1:0];
         irq_r    <= |(irqSt_r & irqMsk_r);
      end
   end
   assign irq = irq_r;

   // write address / data capture and response
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         awHeld_r     <= 1'b0;
         wHeld_r      <= 1'b0;
         awAddr_r     <= 12'h000;
         wData_r      <= 8'h00;
         wLane0_r     <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= DDC_RESP_OKAY;
      end
      else
      begin
         if (awTake)
         begin
            awHeld_r <= 1'b1;
            awAddr_r <= s_axi_awaddr;
         end
         if (wTake)
         begin
            wHeld_r  <= 1'b1;
            wData_r  <= s_axi_wdata[7:0];
            wLane0_r <= s_axi_wstrb[0];
         end
         if (doWrite)
         begin
            awHeld_r     <= 1'b0;
            wHeld_r      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wrMapped ? DDC_RESP_OKAY : DDC_RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // ready pulses one cycle on the taking edge
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end
      else
      begin
         s_axi_awready <= awTake && !s_axi_awready;
         s_axi_wready  <= wTake && !s_axi_wready;
      end
   end

   // read channel: arready one cycle, data on the same edge
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= DDC_RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= arTake;
         if (arTake)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rdMux;
            s_axi_rresp  <= rdMapped ? DDC_RESP_OKAY : DDC_RESP_SLVERR;
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // drive outputs leave through a register stage
   ddc_outreg #(.W(8)) u_out (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .d       ({driveNxt, ctrl_r[DDC_CS_BIT], comNxt, biasNxt}),
      .q       (outQ)
   );
   assign driveActive       = outQ[7];
   assign clockSelSecondary = outQ[6];
   assign commonCount       = outQ[5:2];
   assign biasSel           = outQ[1:0];
endmodule : ddc_ctrl
`default_nettype wire

/* File: ddc_ctrl_chk.sv */
// checker for the display drive control register block
// assumes it is bound onto ddc_ctrl and sees only its ports
`default_nettype none
module ddc_ctrl_chk
   import ddc_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic        arst_n,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        driveActive,
   input wire logic [3:0]  commonCount,
   input wire logic [1:0]  biasSel,
   input wire logic        irq
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   // both halves of a write offered while no response is pending
   sequence wr_req;
      s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   endsequence
   write_resp_a: assert property (wr_req |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   read_resp_a: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
      else $error("read response late");
   bvalid_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   rvalid_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read response repeated");
   rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("upper read data not zero");
   slverr_zero_a: assert property (s_axi_rvalid && s_axi_rresp == DDC_RESP_SLVERR
      |-> s_axi_rdata == 32'h0)
      else $error("error read returned data");
   // bias follows the commons count: off, static, half, third
   bias_map_a: assert property (biasSel == ((commonCount > 4'h2) ? 2'h3 : commonCount[1:0]))
      else $error("bias does not match commons");
   count_max_a: assert property (commonCount <= 4'h8)
      else $error("commons count above eight");
   idle_commons_a: assert property (!driveActive |-> commonCount == 4'h0)
      else $error("commons driven while idle");
   reset_zero_a: assert property ($rose(arst_n) |-> !driveActive && !irq && biasSel == 2'h0)
      else $error("outputs not clear after reset");
endmodule : ddc_ctrl_chk
bind ddc_ctrl ddc_ctrl_chk i_chk (.ref_clk(ref_clk), .arst_n(arst_n),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_wvalid(s_axi_wvalid), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .driveActive(driveActive), .commonCount(commonCount), .biasSel(biasSel), .irq(irq));
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the display drive control register block
// assumes ddc_ctrl with its bound checker and one 250 MHz clock
`default_nettype none
module tb_top
   import ddc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk, arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, irq, patternWriteFail, sleepMode, driveActive, clkSec, ist, msk;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rnd;
   logic [1:0]  s_axi_bresp, s_axi_rresp, biasSel;
   logic [3:0]  commonCount;
   logic [7:0]  ctl;
   int          failures, checks_done, cyc;
   ddc_ctrl i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .patternWriteFail(patternWriteFail), .sleepMode(sleepMode),
      .driveActive(driveActive), .clockSelSecondary(clkSec), .commonCount(commonCount),
      .biasSel(biasSel), .irq(irq));
   // 4 ns period; the cycle ceiling is far above the 96 transfers run
   always #2 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         failures++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      if (failures == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : wrap_up
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr
   // status word model: drive gated by sleep, count 0 when idle or code above eight
   function automatic logic [31:0] stat(input logic [7:0] c, input logic sl);
      logic       drv;
      logic [3:0] n;
      drv = c[7] && !(c[6] && sl);
      n = (drv && c[3:0] <= 4'h8) ? c[3:0] : 4'h0;
      stat = {24'h0, (n == 4'h0) ? 2'h0 : (n == 4'h1) ? 2'h1 : (n == 4'h2) ? 2'h2 : 2'h3, n, c[4], drv};
   endfunction : stat
   // bus write, then the model takes the same word
   task automatic put(input logic [11:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge ref_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk("bresp", {30'h0, s_axi_bresp}, {30'h0, (a > DDC_IRQMSK_OFS) ? DDC_RESP_SLVERR : DDC_RESP_OKAY});
      if (a == DDC_CTRL_OFS) ctl = {d[7:6], ctl[5] & d[5], d[4], ctl[7] ? ctl[3:0] : d[3:0]};
      if (a == DDC_IRQST_OFS) ist = ist & !d[0];
      if (a == DDC_IRQMSK_OFS) msk = d[0];
   endtask : put
   // bus read compared with the model, plus the decoded output ports
   task automatic get(input logic [11:0] a);
      logic [31:0] s;
      s = stat(ctl, sleepMode);
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge ref_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk("rdata", s_axi_rdata, (a == DDC_CTRL_OFS) ? {24'h0, ctl} : (a == DDC_STAT_OFS) ? s :
         (a == DDC_IRQST_OFS) ? {31'h0, ist} : (a == DDC_IRQMSK_OFS) ? {31'h0, msk} : 32'h0);
      chk("rresp", {30'h0, s_axi_rresp}, (a > DDC_IRQMSK_OFS) ? 32'h2 : 32'h0);
      chk("ports", {23'h0, irq, driveActive, clkSec, biasSel, commonCount},
         {23'h0, ist & msk, s[0], s[1], s[7:2]});
   endtask : get
   task automatic fail_pulse();
      @(posedge ref_clk);
      patternWriteFail <= 1'b1;
      @(posedge ref_clk);
      patternWriteFail <= 1'b0;
      ctl[5] = 1'b1;
      ist = 1'b1;
   endtask : fail_pulse
   initial
   begin
      {ref_clk, arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 6'h0;
      {s_axi_rready, patternWriteFail, sleepMode, ctl, ist, msk} = 13'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
      {failures, checks_done, cyc} = 96'h0;
      rnd = 32'hb84ecae6;
      repeat (2) @(posedge ref_clk);
      arst_n <= 1'b1;
      for (int a = 0; a < 20; a += 4) get(a[11:0]); // reset values and one unmapped place
      put(12'h010, 8'hff);
      put(DDC_STAT_OFS, 8'hff);
      // every common code, then disable with a changed code that must be dropped
      for (int i = 0; i < 16; i++)
      begin
         rnd = lfsr(rnd);
         sleepMode <= rnd[9];
         put(DDC_CTRL_OFS, {2'h0, rnd[5:4], rnd[3:0]});
         put(DDC_CTRL_OFS, {1'b1, rnd[6], 1'b1, rnd[4], i[3:0]}); // code i lands while idle
         get(DDC_STAT_OFS); // decoded drive
         put(DDC_CTRL_OFS, {1'b0, rnd[6], 2'h0, rnd[13:10]}); // code held
         get(DDC_CTRL_OFS);
      end
      // failure flag with irq unmasked, then masked
      put(DDC_IRQMSK_OFS, 8'h01);
      fail_pulse();
      get(DDC_IRQST_OFS); // flag and irq set
      put(DDC_CTRL_OFS, ctl);
      get(DDC_CTRL_OFS); // one written keeps the flag
      put(DDC_IRQST_OFS, 8'h01);
      put(DDC_CTRL_OFS, ctl & 8'hdf);
      get(DDC_CTRL_OFS); // zero written clears it
      put(DDC_IRQMSK_OFS, 8'h00);
      fail_pulse();
      get(DDC_IRQST_OFS);
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
